// *** rtl/rwd_watchdog.sv ***
// The register addresses and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
// Operation
// RULE1: enable bit and counter run from reset
// RULE2: stop only on B1H with enable cleared
// RULE3: setting enable bit restarts stopped watchdog
// RULE4: link bit routes timeout to internal reset
// RULE5: 4EH clears the counter to zero
// RULE6: software writes 4EH before B1H
// RULE7: software disables before changing settings
// RULE8: other command values do nothing
// RULE9: 22 stages, half-rate, four timeout taps
// RULE10: overflow raises non-maskable runaway interrupt
// RULE11: halts in idle/stop, runs during bus release
// RULE12: linked reset pulse lasts 22-29 clocks
module rwd_watchdog (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        deep_idle_state,
    input  wire logic        stop_state,
    output logic             runaway_interrupt,
    output logic             internal_reset,
    output logic             irq
);
    rwd_pkg::rwd_mode_t           mode_reg;
    logic                         run_reg;
    logic [rwd_pkg::STAT_W-1:0]   status_reg;
    logic [rwd_pkg::STAT_W-1:0]   irq_en_reg;
    logic [4:0]                   rst_cnt_reg;
    logic                         aw_full_reg;
    logic                         w_full_reg;
    logic [7:0]                   aw_addr_reg;
    logic [31:0]                  w_data_reg;
    logic [3:0]                   w_strb_reg;
    logic                         do_write;
    logic                         mode_wr;
    logic                         cmd_wr;
    logic                         clr_cmd;
    logic                         dis_cmd;
    logic                         wr_mapped;
    logic [rwd_pkg::CNT_STAGES-1:0] count;
    logic                         overflow;
    logic [31:0]                  rd_next;
    logic                         rd_ok;

    // ---------------- write channel: address and data taken in either order
    assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_full_reg && !s_axi_bvalid;
    assign do_write      = aw_full_reg && w_full_reg && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn || do_write) begin
            aw_full_reg <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_full_reg <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || do_write) begin
            w_full_reg <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_full_reg <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_addr_reg <= 8'h00;
            w_data_reg  <= 32'h0000_0000;
            w_strb_reg  <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
        end
    end

    always_comb begin
        if (aw_addr_reg == rwd_pkg::MODE_ADDR || aw_addr_reg == rwd_pkg::CMD_ADDR
            || aw_addr_reg == rwd_pkg::CLEAR_ADDR || aw_addr_reg == rwd_pkg::IRQ_EN_ADDR) begin
            wr_mapped = 1'b1;
        end else begin
            wr_mapped = 1'b0;
        end
    end

    assign mode_wr = do_write && w_strb_reg[0] && aw_addr_reg == rwd_pkg::MODE_ADDR;
    assign cmd_wr  = do_write && w_strb_reg[0] && aw_addr_reg == rwd_pkg::CMD_ADDR;
    assign clr_cmd = cmd_wr && w_data_reg[7:0] == rwd_pkg::CODE_CLEAR; // RULE5
    // the disable code alone is ignored while the enable bit still reads 1
    assign dis_cmd = cmd_wr && w_data_reg[7:0] == rwd_pkg::CODE_DISABLE
                     && !mode_reg.run_enable; // RULE2

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= rwd_pkg::RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_mapped ? rwd_pkg::RESP_OKAY : rwd_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ---------------- mode register and run state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_reg.run_enable <= rwd_pkg::EN_RESET; // RULE1
            mode_reg.period_sel <= rwd_pkg::SEL_RESET;
            mode_reg.reset_link <= rwd_pkg::LINK_RESET; // RULE4
        end else if (mode_wr) begin
            mode_reg.run_enable <= w_data_reg[rwd_pkg::MODE_EN_POS];
            mode_reg.period_sel <= w_data_reg[rwd_pkg::MODE_SEL_POS +: 2];
            mode_reg.reset_link <= w_data_reg[rwd_pkg::MODE_LINK_POS];
        end
    end

    // clearing the enable bit by itself does not stop the counter
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_reg <= rwd_pkg::EN_RESET; // RULE1
        end else if (mode_wr && w_data_reg[rwd_pkg::MODE_EN_POS]) begin
            run_reg <= 1'b1; // RULE3
        end else if (dis_cmd) begin
            run_reg <= 1'b0; // RULE2 RULE8
        end
    end

    // bus release is deliberately not an input: counting ignores it
    rwd_counter #(
        .STAGES     (rwd_pkg::CNT_STAGES)
    ) u_counter (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .run        (run_reg),
        .halt       (deep_idle_state || stop_state), // RULE11
        .clear      (clr_cmd), // RULE5
        .period_sel (mode_reg.period_sel),
        .count      (count),
        .overflow   (overflow)
    );

    assign runaway_interrupt = overflow; // RULE10

    // ---------------- internal reset pulse
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rst_cnt_reg <= 5'h00;
        end else if (overflow && mode_reg.reset_link && rst_cnt_reg == 5'h00) begin
            rst_cnt_reg <= 5'(rwd_pkg::RST_PULSE_CYCLES); // RULE4 RULE12
        end else if (rst_cnt_reg != 5'h00) begin
            rst_cnt_reg <= rst_cnt_reg - 5'h01;
        end
    end

    assign internal_reset = rst_cnt_reg != 5'h00;

    // ---------------- sticky status, set wins over a clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_reg <= '0;
        end else begin
            for (int b = 0; b < rwd_pkg::STAT_W; b++) begin
                if ((b == rwd_pkg::STAT_TIMEOUT_POS && overflow)
                    || (b == rwd_pkg::STAT_RST_POS && overflow && mode_reg.reset_link)) begin
                    status_reg[b] <= 1'b1;
                end else if (do_write && w_strb_reg[0] && w_data_reg[b]
                             && aw_addr_reg == rwd_pkg::CLEAR_ADDR) begin
                    status_reg[b] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_en_reg <= '0;
        end else if (do_write && w_strb_reg[0] && aw_addr_reg == rwd_pkg::IRQ_EN_ADDR) begin
            irq_en_reg <= w_data_reg[rwd_pkg::STAT_W-1:0];
        end
    end

    assign irq = |(status_reg & irq_en_reg);

    // ---------------- read channel
    assign s_axi_arready = !s_axi_rvalid;

    always_comb begin
        rd_next = 32'h0000_0000;
        rd_ok   = 1'b1;
        if (s_axi_araddr == rwd_pkg::MODE_ADDR) begin
            rd_next[rwd_pkg::MODE_EN_POS]       = mode_reg.run_enable;
            rd_next[rwd_pkg::MODE_SEL_POS +: 2] = mode_reg.period_sel;
            rd_next[rwd_pkg::MODE_LINK_POS]     = mode_reg.reset_link;
            rd_next[rwd_pkg::MODE_RUN_POS]      = run_reg;
        end else if (s_axi_araddr == rwd_pkg::STATUS_ADDR) begin
            rd_next[rwd_pkg::STAT_W-1:0] = status_reg;
        end else if (s_axi_araddr == rwd_pkg::IRQ_EN_ADDR) begin
            rd_next[rwd_pkg::STAT_W-1:0] = irq_en_reg;
        end else if (s_axi_araddr == rwd_pkg::COUNT_ADDR) begin
            rd_next[rwd_pkg::CNT_STAGES-1:0] = count;
        end else if (s_axi_araddr == rwd_pkg::CMD_ADDR || s_axi_araddr == rwd_pkg::CLEAR_ADDR) begin
            rd_next = 32'h0000_0000;
        end else begin
            rd_ok = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= rwd_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_next;
            s_axi_rresp  <= rd_ok ? rwd_pkg::RESP_OKAY : rwd_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ---------------- assertions
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_reset_run;
        $rose(aresetn) |-> run_reg && mode_reg.run_enable && !mode_reg.reset_link;
    endproperty
    a_reset_run: assert property (p_reset_run) else $error("not running after reset"); // RULE1

    property p_stop_cause;
        $fell(run_reg) |-> $past(cmd_wr) && $past(w_data_reg[7:0]) == rwd_pkg::CODE_DISABLE
                           && !$past(mode_reg.run_enable);
    endproperty
    a_stop_cause: assert property (p_stop_cause) else $error("stopped without disable code"); // RULE2

    property p_resume;
        mode_wr && w_data_reg[rwd_pkg::MODE_EN_POS] |=> run_reg;
    endproperty
    a_resume: assert property (p_resume) else $error("enable bit did not restart"); // RULE3

    property p_link;
        overflow |=> (internal_reset == ($past(mode_reg.reset_link) || $past(internal_reset)));
    endproperty
    a_link: assert property (p_link) else $error("internal reset not per link bit"); // RULE4

    property p_clear;
        clr_cmd |=> count == '0 ##2 count <= 1;
    endproperty
    a_clear: assert property (p_clear) else $error("clear code did not zero counter"); // RULE5

    property p_other_code;
        cmd_wr && !clr_cmd && !dis_cmd |=> $stable(run_reg) && (count != '0 || $past(count) == '0
                                            || $past(count) == '1);
    endproperty
    a_other_code: assert property (p_other_code) else $error("stray code had an effect"); // RULE8

    property p_halt;
        run_reg && (deep_idle_state || stop_state) && !clr_cmd && !$past(clr_cmd)
            |=> $stable(count);
    endproperty
    a_halt: assert property (p_halt) else $error("counter moved while halted"); // RULE11

    property p_nmi;
        runaway_interrupt |=> status_reg[rwd_pkg::STAT_TIMEOUT_POS];
    endproperty
    a_nmi: assert property (p_nmi) else $error("timeout not recorded"); // RULE10

    property p_pulse_len;
        $rose(internal_reset) |-> internal_reset[*8] ##1 internal_reset[*8] ##1 internal_reset[*8]
                                  ##1 internal_reset ##1 !internal_reset;
    endproperty
    a_pulse_len: assert property (p_pulse_len) else $error("reset pulse length wrong"); // RULE12

    property p_step_rate;
        run_reg && !deep_idle_state && !stop_state && !clr_cmd && $changed(count)
            |=> $stable(count) || $past(clr_cmd);
    endproperty
    a_step_rate: assert property (p_step_rate) else $error("counter stepped too fast"); // RULE9

    c_disable: cover property (dis_cmd ##1 !run_reg);
    c_timeout: cover property (overflow && mode_reg.reset_link);
    c_clear:   cover property (clr_cmd);
    c_irq:     cover property ($rose(irq));
endmodule // rwd_watchdog

// *** rtl/rwd_pkg.sv ***
package rwd_pkg;
    // register byte addresses
    localparam logic [7:0] MODE_ADDR     = 8'h00;
    localparam logic [7:0] CMD_ADDR      = 8'h04;
    localparam logic [7:0] STATUS_ADDR   = 8'h08;
    localparam logic [7:0] CLEAR_ADDR    = 8'h0C;
    localparam logic [7:0] IRQ_EN_ADDR   = 8'h10;
    localparam logic [7:0] COUNT_ADDR    = 8'h14;
    // mode register field positions
    localparam int MODE_EN_POS           = 0;
    localparam int MODE_SEL_POS          = 1;
    localparam int MODE_LINK_POS         = 3;
    localparam int MODE_RUN_POS          = 8;
    // status, clear and enable share one layout
    localparam int STAT_TIMEOUT_POS      = 0;
    localparam int STAT_RST_POS          = 1;
    localparam int STAT_W                = 2;
    // command codes
    localparam logic [7:0] CODE_CLEAR    = 8'h4E;
    localparam logic [7:0] CODE_DISABLE  = 8'hB1;
    // reset values
    localparam logic       EN_RESET      = 1'b1;
    localparam logic [1:0] SEL_RESET     = 2'h0;
    localparam logic       LINK_RESET    = 1'b0;
    // counter shape and reset pulse length in system clocks (22 to 29 allowed)
    localparam int CNT_STAGES            = 22;
    localparam int TAP_BASE              = 14;
    localparam int RST_PULSE_CYCLES      = 25;
    localparam logic [1:0] RESP_OKAY     = 2'h0;
    localparam logic [1:0] RESP_SLVERR   = 2'h2;

    typedef struct packed {
        logic       reset_link;
        logic [1:0] period_sel;
        logic       run_enable;
    } rwd_mode_t;
endpackage

// *** rtl/rwd_counter.sv ***
`timescale 1ns/1ps
// binary counter stepped at half the clock rate; overflow at the selected tap
module rwd_counter #(
    parameter int STAGES = rwd_pkg::CNT_STAGES
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic              run,
    input  wire logic              halt,
    input  wire logic              clear,
    input  wire logic [1:0]        period_sel,
    output logic      [STAGES-1:0] count,
    output logic                   overflow
);
    logic              tick_reg;
    logic [STAGES-1:0] mask;
    logic [5:0]        tap;
    logic              step;

    assign tap  = 6'(rwd_pkg::TAP_BASE) + {3'h0, period_sel, 1'b0}; // RULE9
    assign step = run && !halt && tick_reg; // RULE9

    genvar i;
    generate
        for (i = 0; i < STAGES; i++) begin : g_mask
            assign mask[i] = (6'(i) < tap);
        end
    endgenerate

    // divide by two: one step every second clock
    always_ff @(posedge aclk) begin
        if (!aresetn || clear || !run) begin
            tick_reg <= 1'b0;
        end else if (!halt) begin
            tick_reg <= !tick_reg;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || clear || !run) begin
            count <= '0;
        end else if (step) begin
            count <= count + 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || clear) begin
            overflow <= 1'b0;
        end else begin
            overflow <= step && ((count & mask) == mask);
        end
    end
endmodule // rwd_counter

// *** bench/rwd_cpu_model.sv ***
`timescale 1ns/1ps
// software side of the register bus; released lines show the inverse of the last value
module rwd_cpu_model (
    input  wire logic        aclk,
    output logic      [7:0]  s_axi_awaddr,
    output logic             s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic      [31:0] s_axi_wdata,
    output logic      [3:0]  s_axi_wstrb,
    output logic             s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output logic             s_axi_bready,
    output logic      [7:0]  s_axi_araddr,
    output logic             s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output logic             s_axi_rready
);
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [1:0] resp);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr  <= ~a;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                s_axi_wdata  <= ~d;
                s_axi_wstrb  <= ~s;
            end
            if (s_axi_bvalid) begin
                resp = s_axi_bresp;
                s_axi_bready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
                s_axi_araddr  <= ~a;
            end
            if (s_axi_rvalid) begin
                d = s_axi_rdata;
                resp = s_axi_rresp;
                s_axi_rready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask

    // the only way this software turns the watchdog off
    task automatic stop_wd();
        logic [1:0] resp;
        wr(rwd_pkg::MODE_ADDR, 32'h0, 4'hF, resp);
        wr(rwd_pkg::CMD_ADDR, 32'h4E, 4'hF, resp);
        wr(rwd_pkg::CMD_ADDR, 32'hB1, 4'hF, resp);
    endtask
endmodule // rwd_cpu_model

// *** bench/tb.sv ***
`timescale 1ns/1ps
module tb;
    logic        aclk, aresetn, deep_idle_state, stop_state;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        runaway_interrupt, internal_reset, irq;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, cmd;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    logic [31:0] s_axi_wdata, s_axi_rdata, rv, c0;
    integer      seed;
    int          err_count, n_tests, cyc, t0, n, m;
    localparam logic [7:0] CORNER [3] = '{8'hB1, 8'h4F, 8'hB0};

    rwd_watchdog rwd_watchdog_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .deep_idle_state, .stop_state,
        .runaway_interrupt, .internal_reset, .irq);
    rwd_cpu_model rwd_cpu_model_i (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    function automatic logic [31:0] mode_word(input logic en, input logic link, input logic run);
        mode_word = 32'h0;
        mode_word[rwd_pkg::MODE_EN_POS] = en;
        mode_word[rwd_pkg::MODE_LINK_POS] = link;
        mode_word[rwd_pkg::MODE_RUN_POS] = run;
    endfunction

    task automatic chk_eq(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        n_tests++;
        if (!((got >= lo) === 1'b1 && (got <= hi) === 1'b1)) begin
            err_count++;
            $display("[ERR] %0t got %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask

    task automatic w(input logic [7:0] a, input logic [31:0] d);
        rwd_cpu_model_i.wr(a, d, 4'hF, rsp);
    endtask

    task automatic r(input logic [7:0] a);
        rwd_cpu_model_i.rd(a, rv, rsp);
    endtask

    // sel is 0 in both timeout runs, so the shortest tap of 2^15 clocks applies
    task automatic wait_pulse();
        t0 = cyc;
        while (runaway_interrupt !== 1'b1) @(posedge aclk);
        chk_rng(cyc - t0, 32768 - 4, 32768 + 6);
    endtask

    task automatic count_after();
        n = 0;
        m = 0;
        repeat (40) begin
            @(posedge aclk);
            n += (internal_reset === 1'b1);
            m += (runaway_interrupt === 1'b1);
        end
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    // both timeout runs together need about 66k cycles
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            err_count++;
            complete_run();
        end
    end

    initial begin
        {err_count, n_tests, cyc, seed} = {32'd0, 32'd0, 32'd0, 32'd57119};
        {aresetn, deep_idle_state, stop_state} = 3'h0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        r(rwd_pkg::MODE_ADDR);
        chk_eq(rv, mode_word(1'b1, 1'b0, 1'b1));
        chk_eq({29'h0, internal_reset, irq, runaway_interrupt}, 32'h0);
        // a write without the low byte lane must leave the mode register alone
        rwd_cpu_model_i.wr(rwd_pkg::MODE_ADDR, 32'h0, 4'hE, rsp);
        chk_eq({30'h0, rsp}, {30'h0, rwd_pkg::RESP_OKAY});
        r(rwd_pkg::MODE_ADDR);
        chk_eq(rv, mode_word(1'b1, 1'b0, 1'b1));
        r(8'h18);
        chk_eq(rv, 32'h0);
        chk_eq({30'h0, rsp}, {30'h0, rwd_pkg::RESP_SLVERR});
        w(8'h18, 32'h1);
        chk_eq(rsp, rwd_pkg::RESP_SLVERR);
        r(rwd_pkg::COUNT_ADDR);
        c0 = rv;
        t0 = cyc;
        repeat (100) @(posedge aclk);
        r(rwd_pkg::COUNT_ADDR);
        chk_rng(rv - c0, (cyc - t0) / 2 - 2, (cyc - t0) / 2 + 1);
        for (int i = 0; i < 8; i++) begin
            cmd = (i < 3) ? CORNER[i] : 8'($random(seed));
            if (cmd == 8'h4E || cmd == 8'hB1) cmd = (i < 3) ? cmd : 8'h00;
            r(rwd_pkg::COUNT_ADDR);
            c0 = rv;
            w(rwd_pkg::CMD_ADDR, {24'h0, cmd});
            r(rwd_pkg::COUNT_ADDR);
            chk_rng(rv, c0 + 2, c0 + 20);
            r(rwd_pkg::MODE_ADDR);
            chk_eq(rv, mode_word(1'b1, 1'b0, 1'b1));
        end
        w(rwd_pkg::CMD_ADDR, 32'h4E);
        r(rwd_pkg::COUNT_ADDR);
        chk_rng(rv, 0, 6);
        w(rwd_pkg::MODE_ADDR, mode_word(1'b0, 1'b0, 1'b0));
        r(rwd_pkg::MODE_ADDR);
        chk_eq(rv, mode_word(1'b0, 1'b0, 1'b1));
        rwd_cpu_model_i.stop_wd();
        repeat (20) @(posedge aclk);
        r(rwd_pkg::COUNT_ADDR);
        chk_eq(rv, 32'h0);
        w(rwd_pkg::MODE_ADDR, mode_word(1'b1, 1'b0, 1'b0));
        r(rwd_pkg::MODE_ADDR);
        chk_eq(rv, mode_word(1'b1, 1'b0, 1'b1));
        for (int k = 1; k < 3; k++) begin
            {stop_state, deep_idle_state} <= 2'(k);
            r(rwd_pkg::COUNT_ADDR);
            c0 = rv;
            repeat (30) @(posedge aclk);
            r(rwd_pkg::COUNT_ADDR);
            chk_eq(rv, c0);
        end
        {stop_state, deep_idle_state} <= 2'h0;
        w(rwd_pkg::CMD_ADDR, 32'h4E);
        wait_pulse();
        count_after();
        chk_eq(n, 32'h0);
        chk_eq(m, 32'h0);
        r(rwd_pkg::STATUS_ADDR);
        chk_eq(rv, 32'h1);
        chk_eq({31'h0, irq}, 32'h0);
        w(rwd_pkg::IRQ_EN_ADDR, 32'h1);
        chk_eq({31'h0, irq}, 32'h1);
        w(rwd_pkg::IRQ_EN_ADDR, 32'h2);
        chk_eq({31'h0, irq}, 32'h0);
        w(rwd_pkg::CLEAR_ADDR, 32'h1);
        r(rwd_pkg::STATUS_ADDR);
        chk_eq({rv[30:0], irq}, 32'h0);
        rwd_cpu_model_i.stop_wd();
        w(rwd_pkg::MODE_ADDR, mode_word(1'b1, 1'b1, 1'b0));
        wait_pulse();
        count_after();
        chk_rng(n, 22, 29);
        chk_eq(m, 32'h0);
        r(rwd_pkg::STATUS_ADDR);
        chk_eq({rv[30:0], irq}, 32'h7);
        // longest tap: only the field read-back fits in the run budget
        rwd_cpu_model_i.stop_wd();
        w(rwd_pkg::MODE_ADDR, 32'h0000_0007);
        r(rwd_pkg::MODE_ADDR);
        chk_eq(rv, 32'h0000_0107);
        // second reset in mid-run brings back the power-up settings
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        r(rwd_pkg::MODE_ADDR);
        chk_eq(rv, mode_word(1'b1, 1'b0, 1'b1));
        chk_eq({31'h0, internal_reset}, 32'h0);
        r(rwd_pkg::STATUS_ADDR);
        chk_eq(rv, 32'h0);
        complete_run();
    end
endmodule // tb
